// ---- sim/gen_model.sv ----
// generator stand-in that counts while the run bit is set
`timescale 1ns/100ps
`default_nettype none

module gen_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // run bit in, generator outputs out
  input wire logic run,
  output logic [3:0] gen_out
);
  logic [3:0] nxt_cnt;
  logic [3:0] cnt_ff;
  always_comb begin
    nxt_cnt = run ? cnt_ff + 4'h1 : cnt_ff;
  end
  // counter register
  always_ff @(posedge clk) begin
    cnt_ff <= rst ? 4'h0 : nxt_cnt;
  end
  // a stopped generator holds its last output
  assign gen_out = cnt_ff;
endmodule // gen_model
`default_nettype wire

// ---- sim/pwm_brake_control_tb.sv ----
// self-checking bench of the pwm brake block
`timescale 1ns/100ps
`default_nettype none

module pwm_brake_control_tb;
  typedef struct packed {
    logic [7:0] cfg;
    logic run;
    logic pin;
    logic brk;
  } row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  brake_pkg::bus_req_t req = '0;
  logic pin = 1'b1;
  logic [7:0] rdata, d2, d3, rv;
  logic [3:0] gen_out, pwm_out, g;
  logic [3:0] gen_q = 4'h0;
  logic run, brk, irq, pb;
  int err_total = 0;
  int total_checks = 0;
  // config, run bit, pin level, brake expected
  row_t rows [9] = '{{8'h65, 3'b110}, {8'h1a, 3'b111}, {8'h93, 3'b110},
    {8'h93, 3'b011}, {8'h3c, 3'b101}, {8'h3c, 3'b110}, {8'h7c, 3'b111},
    {8'h7c, 3'b100}, {8'hb5, 3'b000}};

  // 50 ns clock
  always #25 clk = ~clk;
  // generator value one cycle back, as pwm_out lags it
  always @(posedge clk) gen_q <= gen_out;

  pwm_brake_control pwm_brake_control_i (.clk(clk), .rst(rst),
    .bus_req(req), .rdata(rdata), .gen_out(gen_out), .generator_run(run),
    .ch2_duty_low(d2), .ch3_duty_low(d3), .brake_input_pin(pin),
    .pwm_out(pwm_out), .brake_asserted(brk), .irq(irq));
  gen_model gen_model_i (.clk(clk), .rst(rst), .run(run),
    .gen_out(gen_out));

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1 d = rdata;
  endtask
  // write then read back with no gap between the strobes
  task automatic wrrd(input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1 q = rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic setpin(input logic v);
    @(posedge clk);
    pin <= v;
  endtask
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // watchdog, well past the length of the sequence
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    finish_test();
  end

  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    chk("pwm_out", 8'h00, {4'h0, pwm_out});
    rd(brake_pkg::OFS_BRAKE_CONFIG, rv);
    chk("config", 8'h00, rv);
    rd(8'he0, rv);
    chk("unmapped", 8'h00, rv);
    wrrd(brake_pkg::OFS_BRAKE_CONFIG, 8'h0a, rv);
    chk("cfg readback", 8'h0a, rv);
    wr(brake_pkg::OFS_CH2_DUTY_LOW, 8'ha5);
    wr(brake_pkg::OFS_CH3_DUTY_LOW, 8'h5a);
    wr(brake_pkg::OFS_IRQ_STATUS, 8'hff);
    rd(brake_pkg::OFS_CH2_DUTY_LOW, rv);
    chk("ch2 duty", 8'ha5, rv);
    rd(brake_pkg::OFS_CH3_DUTY_LOW, rv);
    chk("ch3 duty", 8'h5a, rv);
    chk("ch2 port", 8'ha5, d2);
    chk("ch3 port", 8'h5a, d3);
    rd(brake_pkg::OFS_IRQ_STATUS, rv);
    chk("status ro", 8'h00, rv);
    wr(brake_pkg::OFS_GEN_CTRL, 8'h80);
    rd(brake_pkg::OFS_GEN_CTRL, rv);
    chk("run reg", 8'h80, rv);
    wr(brake_pkg::OFS_IRQ_ENABLE, 8'h01);
    // rows cover each mode, both pin polarities and levels, and both idle run states
    foreach (rows[i]) begin
      setpin(rows[i].pin);
      wr(brake_pkg::OFS_GEN_CTRL, {rows[i].run, 7'h00});
      wr(brake_pkg::OFS_BRAKE_CONFIG, rows[i].cfg);
      cyc(6);
      pb = rows[i].brk & rows[i].cfg[5];
      chk("brake", {7'h00, rows[i].brk}, {7'h00, brk});
      g = rows[i].brk ? rows[i].cfg[3:0] : gen_q;
      chk("pwm_out", {4'h0, g}, {4'h0, pwm_out});
      chk("run", {7'h00, rows[i].run & ~pb}, {7'h00, run});
      rd(brake_pkg::OFS_IRQ_STATUS, rv);
      chk("flag", {7'h00, pb}, rv);
      chk("irq", {7'h00, pb}, {7'h00, irq});
      setpin(~rows[i].cfg[6]);
      cyc(3);
      wr(brake_pkg::OFS_BRAKE_CONFIG, 8'h00);
      wr(brake_pkg::OFS_IRQ_CLEAR, 8'h01);
    end
    // pin brake stays latched with the pin idle, until enable cleared
    wr(brake_pkg::OFS_IRQ_ENABLE, 8'h00);
    wr(brake_pkg::OFS_GEN_CTRL, 8'h80);
    wr(brake_pkg::OFS_BRAKE_CONFIG, 8'h3c);
    setpin(1'b0);
    cyc(4);
    chk("masked irq", 8'h00, {7'h00, irq});
    wr(brake_pkg::OFS_IRQ_CLEAR, 8'h01);
    rd(brake_pkg::OFS_IRQ_STATUS, rv);
    chk("set wins", 8'h01, rv);
    setpin(1'b1);
    cyc(4);
    chk("latched", 8'h01, {7'h00, brk});
    wr(brake_pkg::OFS_BRAKE_CONFIG, 8'h00);
    cyc(2);
    chk("resume", {4'h0, gen_out}, {4'h0, pwm_out});
    wr(brake_pkg::OFS_IRQ_ENABLE, 8'h01);
    cyc(1);
    chk("sticky irq", 8'h01, {7'h00, irq});
    wr(brake_pkg::OFS_IRQ_CLEAR, 8'h01);
    cyc(1);
    chk("cleared irq", 8'h00, {7'h00, irq});
    // software brake release shows the live generator
    wr(brake_pkg::OFS_GEN_CTRL, 8'h80);
    wr(brake_pkg::OFS_BRAKE_CONFIG, 8'h10);
    cyc(3);
    chk("soft run", 8'h01, {7'h00, run});
    wr(brake_pkg::OFS_BRAKE_CONFIG, 8'h00);
    cyc(2);
    chk("soft release", {4'h0, gen_q}, {4'h0, pwm_out});
    // idle brake release gives the frozen value
    wr(brake_pkg::OFS_GEN_CTRL, 8'h00);
    cyc(1);
    g = gen_out;
    wr(brake_pkg::OFS_BRAKE_CONFIG, 8'h9f);
    cyc(3);
    chk("idle levels", 8'h0f, {4'h0, pwm_out});
    wr(brake_pkg::OFS_BRAKE_CONFIG, 8'h00);
    cyc(2);
    chk("idle release", {4'h0, g}, {4'h0, pwm_out});
    // reset in mid-run under brake
    wr(brake_pkg::OFS_BRAKE_CONFIG, 8'h1f);
    @(posedge clk);
    rst <= 1'b1;
    cyc(2);
    @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    chk("pwm_out", 8'h00, {4'h0, pwm_out});
    rd(brake_pkg::OFS_BRAKE_CONFIG, rv);
    chk("config", 8'h00, rv);
    finish_test();
  end
endmodule // pwm_brake_control_tb
`default_nettype wire

// ---- src/brake_pkg.sv ----
// shared constants and carrier types of the pwm brake block
`default_nettype none

package brake_pkg;

  // register bus widths and channel count
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CHANNELS = 4;

  // register offsets
  localparam logic [7:0] OFS_GEN_CTRL = 8'hdc;
  localparam logic [7:0] OFS_CH2_DUTY_LOW = 8'hdd;
  localparam logic [7:0] OFS_CH3_DUTY_LOW = 8'hde;
  localparam logic [7:0] OFS_BRAKE_CONFIG = 8'hdf;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'hf0;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'hf1;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'hf2;

  // field positions
  localparam int RUN_BIT = 7;
  localparam int FLAG_BIT = 0;

  // reset values
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic RST_RUN = 1'b0;
  localparam logic RST_FLAG = 1'b0;
  localparam logic RST_IRQ_EN = 1'b0;

  // brake configuration register, msb first
  typedef struct packed {
    logic mode_select;
    logic pin_polarity;
    logic pin_mode;
    logic enable;
    logic [3:0] levels;
  } brake_cfg_t;

  // brake modes as {brake_pin_mode, brake_mode_select}
  typedef enum logic [1:0] {
    MODE_SOFT = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_PIN = 2'b10,
    MODE_NONE = 2'b11
  } brake_mode_t;

  // one register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

endpackage

`default_nettype wire

// ---- src/pin_sync.sv ----
// two-stage synchroniser for an asynchronous input pin
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // asynchronous input and its synchronised copy
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule // pin_sync

`default_nettype wire

// ---- src/pwm_brake_control.sv ----
// brake logic and low duty registers of the four-channel pwm unit
//
// Behaviour
// - with brake_enable at 0 the brake is never asserted.
// - brake_pin_mode and brake_mode_select both 1 give no brake at all.
// - brake_pin_polarity 0 makes a low pin active, 1 makes a high pin active.
// - under brake each output shows its own chan_brake_level bit.
// - software brake forces levels and leaves generator_run untouched.
// - leaving software brake, outputs take the live generator value at once.
// - idle brake applies levels only while generator_run is 0.
// - clearing brake_enable in idle brake restores the frozen generator value.
// - pin brake forces levels, clears generator_run and sets brake_flag.
// - pin brake ends only when brake_enable is cleared, whatever the pin level.
// - generator_run bit 7 of the control register runs or stops the counter.
`timescale 1ns/100ps
`default_nettype none

module pwm_brake_control (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port, read data one cycle after the read strobe
  input wire brake_pkg::bus_req_t bus_req,
  output logic [7:0] rdata,
  // generator side
  input wire logic [3:0] gen_out,
  output logic generator_run,
  output logic [7:0] ch2_duty_low,
  output logic [7:0] ch3_duty_low,
  // pins and interrupt
  input wire logic brake_input_pin,
  output logic [3:0] pwm_out,
  output logic brake_asserted,
  output logic irq
);

  // register state
  brake_pkg::brake_cfg_t cfg_ff, nxt_cfg;
  logic [7:0] duty2_ff, nxt_duty2;
  logic [7:0] duty3_ff, nxt_duty3;
  logic run_ff, nxt_run;
  logic flag_ff, nxt_flag;
  logic irq_en_ff, nxt_irq_en;
  logic [7:0] rdata_ff, nxt_rdata;
  // brake state
  logic pin_latch_ff, nxt_pin_latch;
  logic [3:0] pwm_out_ff, nxt_pwm_out;
  // combinational terms
  logic pin_sync_lvl;
  logic pin_active;
  logic brake_on;
  logic pin_brake;
  brake_pkg::brake_mode_t mode;

  // pin passes two flops before anything reads it
  pin_sync #(
    .WIDTH(1)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .async_in(brake_input_pin),
    .sync_out(pin_sync_lvl)
  );

  assign pin_active = (pin_sync_lvl == cfg_ff.pin_polarity);

  // mode code as {brake_pin_mode, brake_mode_select}
  assign mode = brake_pkg::brake_mode_t'(
    {cfg_ff.pin_mode, cfg_ff.mode_select});

  // brake decision, latched pin brake keeps it until release
  always_comb begin
    brake_on = 1'b0;
    pin_brake = 1'b0;
    if (cfg_ff.enable) begin
      unique case (mode)
        // software brake, run bit left alone
        brake_pkg::MODE_SOFT: brake_on = 1'b1;
        brake_pkg::MODE_IDLE: brake_on = !run_ff;
        brake_pkg::MODE_PIN: begin
          pin_brake = pin_active;
          brake_on = pin_active || pin_latch_ff;
        end
        brake_pkg::MODE_NONE: brake_on = 1'b0;
      endcase
    end
  end

  // pin brake latch and output select
  always_comb begin
    nxt_pin_latch = pin_latch_ff;
    // release by clearing brake_enable
    // a still active pin does not relatch, and no stale polarity holds it
    if (pin_brake) begin
      nxt_pin_latch = 1'b1;
    end else if (!cfg_ff.enable) begin
      nxt_pin_latch = 1'b0;
    end
    if (brake_on) begin
      nxt_pwm_out = cfg_ff.levels;
    end else begin
      // stopped generator still holds its last value
      nxt_pwm_out = gen_out;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_latch_ff <= 1'b0;
      pwm_out_ff <= 4'h0;
    end else begin
      pin_latch_ff <= nxt_pin_latch;
      pwm_out_ff <= nxt_pwm_out;
    end
  end

  // register writes, hardware events and read data
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_duty2 = duty2_ff;
    nxt_duty3 = duty3_ff;
    nxt_run = run_ff;
    nxt_flag = flag_ff;
    nxt_irq_en = irq_en_ff;
    nxt_rdata = 8'h00;
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        brake_pkg::OFS_GEN_CTRL: nxt_run = bus_req.wdata[brake_pkg::RUN_BIT];
        brake_pkg::OFS_CH2_DUTY_LOW: nxt_duty2 = bus_req.wdata;
        brake_pkg::OFS_CH3_DUTY_LOW: nxt_duty3 = bus_req.wdata;
        brake_pkg::OFS_BRAKE_CONFIG: nxt_cfg = bus_req.wdata;
        brake_pkg::OFS_IRQ_CLEAR: begin
          if (bus_req.wdata[brake_pkg::FLAG_BIT]) begin
            nxt_flag = 1'b0;
          end
        end
        brake_pkg::OFS_IRQ_ENABLE: begin
          nxt_irq_en = bus_req.wdata[brake_pkg::FLAG_BIT];
        end
        default: ;
      endcase
    end
    // hardware stop wins over a software start
    // set wins over a clear in the same cycle
    if (pin_brake) begin
      nxt_run = 1'b0;
      nxt_flag = 1'b1;
    end
    // unmapped and write-only offsets read as zero
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        brake_pkg::OFS_GEN_CTRL: nxt_rdata[brake_pkg::RUN_BIT] = run_ff;
        brake_pkg::OFS_CH2_DUTY_LOW: nxt_rdata = duty2_ff;
        brake_pkg::OFS_CH3_DUTY_LOW: nxt_rdata = duty3_ff;
        brake_pkg::OFS_BRAKE_CONFIG: nxt_rdata = cfg_ff;
        brake_pkg::OFS_IRQ_STATUS: nxt_rdata[brake_pkg::FLAG_BIT] = flag_ff;
        brake_pkg::OFS_IRQ_ENABLE: begin
          nxt_rdata[brake_pkg::FLAG_BIT] = irq_en_ff;
        end
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_ff <= brake_pkg::RST_CONFIG;
      duty2_ff <= brake_pkg::RST_DUTY;
      duty3_ff <= brake_pkg::RST_DUTY;
      run_ff <= brake_pkg::RST_RUN;
      flag_ff <= brake_pkg::RST_FLAG;
      irq_en_ff <= brake_pkg::RST_IRQ_EN;
      rdata_ff <= 8'h00;
    end else begin
      cfg_ff <= nxt_cfg;
      duty2_ff <= nxt_duty2;
      duty3_ff <= nxt_duty3;
      run_ff <= nxt_run;
      flag_ff <= nxt_flag;
      irq_en_ff <= nxt_irq_en;
      rdata_ff <= nxt_rdata;
    end
  end

  // outputs, all from flops except the brake and irq levels
  assign rdata = rdata_ff;
  assign generator_run = run_ff;
  assign ch2_duty_low = duty2_ff;
  assign ch3_duty_low = duty3_ff;
  assign pwm_out = pwm_out_ff;
  assign brake_asserted = brake_on;
  // flag shown as a level interrupt
  assign irq = flag_ff && irq_en_ff;

  // checks on the design's own outputs
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic cfg_wr;
  logic ctrl_wr;
  logic clr_wr;
  assign cfg_wr = bus_req.wr && (bus_req.addr == brake_pkg::OFS_BRAKE_CONFIG);
  assign ctrl_wr = bus_req.wr && (bus_req.addr == brake_pkg::OFS_GEN_CTRL);
  assign clr_wr = bus_req.wr && (bus_req.addr == brake_pkg::OFS_IRQ_CLEAR);

  a_disabled_no_brake: assert property (
    !cfg_ff.enable |=> pwm_out == $past(gen_out))
    else $error("brake acted while disabled");

  a_reserved_mode_inert: assert property (
    (cfg_ff.enable && cfg_ff.pin_mode && cfg_ff.mode_select)
      |-> !brake_asserted && !pin_latch_ff)
    else $error("reserved brake mode acted");

  a_pin_polarity: assert property (
    (cfg_ff.enable && mode == brake_pkg::MODE_PIN
      && pin_sync_lvl == cfg_ff.pin_polarity) |-> brake_asserted)
    else $error("active brake pin ignored");

  a_brake_levels: assert property (
    brake_asserted |=> pwm_out == $past(cfg_ff.levels))
    else $error("output not at brake level");

  a_soft_keeps_run: assert property (
    (cfg_ff.enable && mode == brake_pkg::MODE_SOFT && !ctrl_wr)
      |=> generator_run == $past(generator_run))
    else $error("software brake changed run bit");

  a_release_live: assert property (
    (brake_asserted ##1 !brake_asserted) |=> pwm_out == $past(gen_out))
    else $error("release did not follow generator");

  // idle brake tracks the run bit
  a_idle_follows_run: assert property (
    (cfg_ff.enable && mode == brake_pkg::MODE_IDLE)
      |-> brake_asserted == !generator_run)
    else $error("idle brake wrong for run state");

  // pin brake stops generator and flags
  a_pin_stops_run: assert property (
    (cfg_ff.enable && mode == brake_pkg::MODE_PIN && pin_active)
      |=> !generator_run && flag_ff && pwm_out == $past(cfg_ff.levels))
    else $error("pin brake did not stop and flag");

  a_pin_hold: assert property (
    (pin_latch_ff && cfg_ff.enable && mode == brake_pkg::MODE_PIN)
      |-> brake_asserted)
    else $error("pin brake released while enabled");

  a_flag_sticky: assert property (
    (flag_ff && !(clr_wr && bus_req.wdata[brake_pkg::FLAG_BIT]))
      |=> flag_ff)
    else $error("brake flag dropped without clear");

  // software write sets run unless pin brake
  a_run_write: assert property (
    (ctrl_wr && !pin_brake) |=>
      generator_run == $past(bus_req.wdata[brake_pkg::RUN_BIT]))
    else $error("run bit write lost");

  // config write visible on readback path next cycle
  a_cfg_write: assert property (
    (cfg_wr ##1 bus_req.rd && bus_req.addr == brake_pkg::OFS_BRAKE_CONFIG)
      |=> rdata == $past(bus_req.wdata, 2))
    else $error("config readback mismatch");

  // clearing enable drops the pin latch
  a_latch_release: assert property (
    !cfg_ff.enable |=> !pin_latch_ff)
    else $error("pin latch kept after release");

  a_set_beats_clear: assert property (
    (pin_brake && clr_wr) |=> flag_ff)
    else $error("flag clear won over pin brake");

  a_flag_readback: assert property (
    (bus_req.rd && bus_req.addr == brake_pkg::OFS_IRQ_STATUS)
      |=> rdata == {7'h00, $past(flag_ff)})
    else $error("status read lost the flag");

  // stopped generator value shown after idle release
  a_idle_release: assert property (
    (cfg_ff.enable && mode == brake_pkg::MODE_IDLE ##1 !cfg_ff.enable)
      |=> pwm_out == $past(gen_out))
    else $error("idle release lost generator value");

endmodule // pwm_brake_control

`default_nettype wire
